//--- rtl/cdsc_consts.svh
// constants for the clock divider sync control block: offsets, field positions, reset values
// assumes it is included by bare name from every design file that needs it
`ifndef CDSC_CONSTS_SVH
`define CDSC_CONSTS_SVH

// register offsets on the serial port (13-bit address space)
`define CDSC_ADDR_OUT_MODE   13'h0014
`define CDSC_ADDR_SIG_HIGH   13'h0025
`define CDSC_ADDR_DITHER     13'h0030
`define CDSC_ADDR_SYNC       13'h0100

// field positions
`define CDSC_SYNC_MASTER_BIT 0
`define CDSC_SYNC_DIV_BIT    1
`define CDSC_SYNC_NEXT_BIT   2
`define CDSC_DITHER_EN_BIT   4
`define CDSC_OUT_TYPE_BIT    6

// reset values
`define CDSC_RST_SYNC        3'h0
`define CDSC_RST_DITHER      1'h0
`define CDSC_RST_OUT_TYPE    1'h0

// serial framing counts
`define CDSC_INSTR_LAST      4'hf
`define CDSC_BYTE_LAST       3'h7
`define CDSC_INSTR_RW_BIT    14
`define CDSC_ADDR_W          13

`endif

//--- rtl/cdsc_pkg.sv
// types shared by the clock divider sync control block
// assumes cdsc_consts.svh supplies all numeric constants
package cdsc_pkg;

  // stored fields of the sync control register, bit 2 down to bit 0
  typedef struct packed {
    logic next_only;
    logic div_en;
    logic master_en;
  } cdsc_sync_ctrl_s;

  // serial port transfer phase
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_WRITE,
    PH_READ
  } cdsc_phase_e;

  // pins that pass through the synchroniser together
  typedef struct packed {
    logic sclk;
    logic csb;
    logic sdio;
    logic sync;
    logic out_dis;
  } cdsc_pins_s;

endpackage

//--- rtl/cdsc_sync_gate.sv
// sync pulse gate for the input clock divider
// assumes sync_lvl is already synchronised to clk_sys; one clock, synchronous reset
`timescale 1ns/1ns
`include "cdsc_consts.svh"

module cdsc_sync_gate
(
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire logic                     sync_lvl,
  input  wire cdsc_pkg::cdsc_sync_ctrl_s ctrl,
  output logic                          realign_q,
  output logic                          clear_div_q
);

  logic sync_prev_q;
  logic sync_prev_d;
  logic realign_d;
  logic clear_div_d;
  logic pulse;

  // rising edge of the sync level is one pulse; gated by both enables
  always_comb
  begin
    sync_prev_d = sync_lvl;
    pulse       = sync_lvl & ~sync_prev_q;
    realign_d   = pulse & ctrl.master_en & ctrl.div_en;
    // one-shot: with next_only set, the first passed pulse drops the divider enable, later pulses find it low
    clear_div_d = realign_d & ctrl.next_only;
  end

  // registers only
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync_prev_q <= 1'h0;
      realign_q   <= 1'h0;
      clear_div_q <= 1'h0;
    end
    else
    begin
      sync_prev_q <= sync_prev_d;
      realign_q   <= realign_d;
      clear_div_q <= clear_div_d;
    end
  end

endmodule

//--- rtl/cdsc_top.sv
// clock divider sync control: serial register port, sync gate, output mode and disable
// assumes serial port pins, sync input and output disable pin are asynchronous to clk_sys
`timescale 1ns/1ns
`include "cdsc_consts.svh"

module cdsc_top
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_csb,
  input  wire logic        spi_sdio_i,
  output logic             spi_sdio_o,
  output logic             spi_sdio_oe_n,
  input  wire logic        sync_in,
  input  wire logic        output_disable_pin,
  input  wire logic [15:0] adc_data,
  input  wire logic [7:0]  self_test_signature_high,
  output logic [15:0]      data_out_q,
  output logic             data_out_en_q,
  output logic             lvds_mode_q,
  output logic             dither_en_q,
  output logic             divider_realign_q
);

  localparam int AW = `CDSC_ADDR_W;

  // synchroniser stages
  cdsc_pkg::cdsc_pins_s pins_s1_q;
  cdsc_pkg::cdsc_pins_s pins_s2_q;
  cdsc_pkg::cdsc_pins_s pins_d;
  logic                 sclk_s3_q;

  // serial port state
  cdsc_pkg::cdsc_phase_e phase_q, phase_d;
  logic [15:0]           shift_q, shift_d;
  logic [3:0]            icnt_q, icnt_d;
  logic [2:0]            bcnt_q, bcnt_d;
  logic [AW-1:0]         addr_q, addr_d;
  logic [7:0]            tx_q, tx_d;
  logic                  sdio_o_q, sdio_o_d;
  logic                  oe_n_q, oe_n_d;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  wr_en;
  logic [AW-1:0]         wr_addr;
  logic [7:0]            wr_data;

  // registers
  cdsc_pkg::cdsc_sync_ctrl_s sync_q, sync_d;
  logic                      dither_q, dither_d;
  logic                      out_type_q, out_type_d;
  logic                      gate_clear;

  // data path
  logic [15:0] data_out_d;
  logic        data_out_en_d;

  // read mux; open bits and unmapped addresses read zero
  function automatic logic [7:0] rd_byte(input logic [AW-1:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `CDSC_ADDR_SYNC:     r = {5'h00, sync_q};
      `CDSC_ADDR_DITHER:   r[`CDSC_DITHER_EN_BIT] = dither_q;
      `CDSC_ADDR_OUT_MODE: r[`CDSC_OUT_TYPE_BIT] = out_type_q;
      `CDSC_ADDR_SIG_HIGH: r = self_test_signature_high;
      default:             r = 8'h00;
    endcase
    return r;
  endfunction

  // two flops on every pin before use; logic reads stage two, plus a third sclk flop for edge detection
  always_comb
  begin
    pins_d.sclk    = spi_sclk;
    pins_d.csb     = spi_csb;
    pins_d.sdio    = spi_sdio_i;
    pins_d.sync    = sync_in;
    pins_d.out_dis = output_disable_pin;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pins_s1_q <= 5'h09;   // csb and output disable idle high
      pins_s2_q <= 5'h09;
      sclk_s3_q <= 1'h0;
    end
    else
    begin
      pins_s1_q <= pins_d;
      pins_s2_q <= pins_s1_q;
      sclk_s3_q <= pins_s2_q.sclk;
    end
  end

  // serial port: 16-bit instruction, then bytes msb first with address counting down
  always_comb
  begin
    phase_d   = phase_q;
    shift_d   = shift_q;
    icnt_d    = icnt_q;
    bcnt_d    = bcnt_q;
    addr_d    = addr_q;
    tx_d      = tx_q;
    sdio_o_d  = sdio_o_q;
    oe_n_d    = oe_n_q;
    wr_en     = 1'h0;
    wr_addr   = addr_q;
    wr_data   = {shift_q[6:0], pins_s2_q.sdio};
    sclk_rise = pins_s2_q.sclk & ~sclk_s3_q;
    sclk_fall = ~pins_s2_q.sclk & sclk_s3_q;
    if (pins_s2_q.csb)
    begin
      // deselect ends any transfer and releases the data line
      phase_d = cdsc_pkg::PH_INSTR;
      icnt_d  = 4'h0;
      bcnt_d  = 3'h0;
      oe_n_d  = 1'h1;
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_d = {shift_q[14:0], pins_s2_q.sdio};
        case (phase_q)
          cdsc_pkg::PH_INSTR:
          begin
            icnt_d = icnt_q + 4'h1;
            if (icnt_q == `CDSC_INSTR_LAST)
            begin
              addr_d  = {shift_q[AW-2:0], pins_s2_q.sdio};
              bcnt_d  = 3'h0;
              tx_d    = rd_byte({shift_q[AW-2:0], pins_s2_q.sdio});
              phase_d = shift_q[`CDSC_INSTR_RW_BIT] ? cdsc_pkg::PH_READ : cdsc_pkg::PH_WRITE;
            end
          end
          cdsc_pkg::PH_WRITE:
          begin
            bcnt_d = bcnt_q + 3'h1;
            if (bcnt_q == `CDSC_BYTE_LAST)
            begin
              wr_en  = 1'h1;
              addr_d = addr_q - 13'h0001;
            end
          end
          cdsc_pkg::PH_READ:
          begin
            bcnt_d = bcnt_q + 3'h1;
            if (bcnt_q == `CDSC_BYTE_LAST)
            begin
              addr_d = addr_q - 13'h0001;
              tx_d   = rd_byte(addr_q - 13'h0001);
            end
          end
          default:
          begin
            phase_d = cdsc_pkg::PH_INSTR;
          end
        endcase
      end
      // read data changes on the falling edge so the host samples it on the rising one
      if (sclk_fall && (phase_q == cdsc_pkg::PH_READ))
      begin
        sdio_o_d = tx_q[~bcnt_q];
        oe_n_d   = 1'h0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      phase_q  <= cdsc_pkg::PH_INSTR;
      shift_q  <= 16'h0000;
      icnt_q   <= 4'h0;
      bcnt_q   <= 3'h0;
      addr_q   <= 13'h0000;
      tx_q     <= 8'h00;
      sdio_o_q <= 1'h0;
      oe_n_q   <= 1'h1;
    end
    else
    begin
      phase_q  <= phase_d;
      shift_q  <= shift_d;
      icnt_q   <= icnt_d;
      bcnt_q   <= bcnt_d;
      addr_q   <= addr_d;
      tx_q     <= tx_d;
      sdio_o_q <= sdio_o_d;
      oe_n_q   <= oe_n_d;
    end
  end

  // register file; a host write beats the one-shot self clear in the same cycle
  always_comb
  begin
    sync_d     = sync_q;
    dither_d   = dither_q;
    out_type_d = out_type_q;
    if (gate_clear)
    begin
      sync_d.div_en = 1'h0;
    end
    if (wr_en)
    begin
      case (wr_addr)
        `CDSC_ADDR_SYNC:     sync_d     = wr_data[2:0];
        `CDSC_ADDR_DITHER:   dither_d   = wr_data[`CDSC_DITHER_EN_BIT];
        `CDSC_ADDR_OUT_MODE: out_type_d = wr_data[`CDSC_OUT_TYPE_BIT];
        default:             sync_d     = sync_d;                    // unmapped: ignored
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync_q     <= `CDSC_RST_SYNC;
      dither_q   <= `CDSC_RST_DITHER;
      out_type_q <= `CDSC_RST_OUT_TYPE;
    end
    else
    begin
      sync_q     <= sync_d;
      dither_q   <= dither_d;
      out_type_q <= out_type_d;
    end
  end

  // gate lives apart so the divider sees only qualified pulses
  cdsc_sync_gate u_gate
  (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .sync_lvl    (pins_s2_q.sync),
    .ctrl        (sync_q),
    .realign_q   (divider_realign_q),
    .clear_div_q (gate_clear)
  );

  // data outputs held at zero while disabled, so a terminated bus sees no toggling
  always_comb
  begin
    data_out_en_d = ~pins_s2_q.out_dis;
    data_out_d    = data_out_en_d ? adc_data : 16'h0000;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      data_out_q    <= 16'h0000;
      data_out_en_q <= 1'h0;
      lvds_mode_q   <= 1'h0;          // cmos after reset
      dither_en_q   <= 1'h0;
    end
    else
    begin
      data_out_q    <= data_out_d;
      data_out_en_q <= data_out_en_d;
      lvds_mode_q   <= out_type_d;    // follows the output type field
      dither_en_q   <= dither_d;
    end
  end

  assign spi_sdio_o    = sdio_o_q;
  assign spi_sdio_oe_n = oe_n_q;

endmodule

//--- test/cdsc_monitor.sv
// checker for the cdsc_top ports, bound to every instance of it
// assumes inputs change just after clk_sys rising edges
`timescale 1ns/1ns
module cdsc_monitor
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        spi_sclk,
  input wire logic        spi_csb,
  input wire logic        spi_sdio_i,
  input wire logic        spi_sdio_o,
  input wire logic        spi_sdio_oe_n,
  input wire logic        sync_in,
  input wire logic        output_disable_pin,
  input wire logic [15:0] adc_data,
  input wire logic [7:0]  self_test_signature_high,
  input wire logic [15:0] data_out_q,
  input wire logic        data_out_en_q,
  input wire logic        lvds_mode_q,
  input wire logic        dither_en_q,
  input wire logic        divider_realign_q
);
  logic       sync_prev_q;
  logic [2:0] since_q;
  logic [2:0] since_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // cycles since the sync pin rose; saturates so an old pulse cannot excuse a realign
  always_comb
  begin
    since_d = (since_q == 3'h7) ? since_q : since_q + 3'h1;
    if (sync_in && !sync_prev_q)
      since_d = 3'h0;
  end
  always_ff @(posedge clk_sys)
  begin
    sync_prev_q <= srst ? 1'b0 : sync_in;
    since_q     <= srst ? 3'h7 : since_d;
  end
  // pin held for a settled stretch, covering the synchroniser latency
  sequence s_dis_held;
    output_disable_pin [*5];
  endsequence
  sequence s_en_held;
    !output_disable_pin [*5];
  endsequence
  AST_REALIGN_CAUSE: assert property (divider_realign_q |-> since_q inside {[3'h1:3'h3]})
    else $error("realign without a recent sync pulse");
  AST_REALIGN_ONE: assert property (divider_realign_q |=> !divider_realign_q)
    else $error("realign pulse longer than one cycle");
  AST_DIS_OFF: assert property (s_dis_held |-> !data_out_en_q)
    else $error("outputs enabled while disable pin high");
  AST_DIS_ZERO: assert property (s_dis_held |-> data_out_q == 16'h0)
    else $error("data not zero while disabled");
  AST_EN_ON: assert property (s_en_held |-> data_out_en_q)
    else $error("outputs not enabled with disable pin low");
  AST_EN_DATA: assert property (s_en_held |-> data_out_q == $past(adc_data))
    else $error("data not passed one cycle late");
  AST_OE_IDLE: assert property (spi_csb [*5] |-> spi_sdio_oe_n)
    else $error("serial data driven outside a frame");
  AST_CFG_IN_FRAME: assert property ($changed({lvds_mode_q, dither_en_q}) |-> !$past(spi_csb, 2))
    else $error("mode changed with no serial frame");
endmodule
bind cdsc_top cdsc_monitor u_mon (.clk_sys, .srst, .spi_sclk, .spi_csb, .spi_sdio_i, .spi_sdio_o,
  .spi_sdio_oe_n, .sync_in, .output_disable_pin, .adc_data, .self_test_signature_high, .data_out_q,
  .data_out_en_q, .lvds_mode_q, .dither_en_q, .divider_realign_q);

//--- test/cdsc_host_model.sv
// serial host and sync pulse source facing cdsc_top
// assumes clk_sys is the device clock; all pins change just after its rising edge
`timescale 1ns/1ns
module cdsc_host_model
(
  input  wire logic clk_sys,
  input  wire logic spi_sdio_o,
  input  wire logic spi_sdio_oe_n,
  output logic      spi_sclk,
  output logic      spi_csb,
  output logic      spi_sdio_i,
  output logic      sync_in
);
  logic bit_q = 1'b0;
  logic drv_q = 1'b0;
  logic junk_q = 1'b0;
  initial
  begin
    spi_sclk = 1'b0; // clock stands still between frames
    spi_csb = 1'b1;
    sync_in = 1'b0;
  end
  // a released line shows a toggling pattern, never the last driven bit
  always @(posedge clk_sys)
    junk_q <= !junk_q;
  assign spi_sdio_i = drv_q ? bit_q : (!spi_sdio_oe_n ? spi_sdio_o : junk_q);
  // one frame: instruction msb first then one byte; phases of 4 cycles keep sclk slow
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] w;
    w = {rd, 2'h0, a, wd}; // output type is set only by frames like this
    spi_csb <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 23; i >= 0; i--)
    begin
      spi_sclk <= 1'b0;
      bit_q <= w[i];
      drv_q <= !(rd && i < 8);
      repeat (4) @(posedge clk_sys);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      if (i < 8)
        q[i] = spi_sdio_i;
    end
    spi_sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    spi_csb <= 1'b1;
    drv_q <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  // one sync pulse, spaced well apart from the next
  task automatic pulse;
    sync_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sync_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

//--- test/cdsc_tb_top.sv
// testbench for cdsc_top: register frames, sync gating and output disable
// assumes the host model drives the serial and sync pins
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module cdsc_tb_top;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        output_disable_pin = 1'b1;
  logic [15:0] adc_data = 16'hbeef;
  logic [7:0]  self_test_signature_high = 8'h5a;
  logic        spi_sclk, spi_csb, spi_sdio_i, spi_sdio_o, spi_sdio_oe_n, sync_in;
  logic [15:0] data_out_q;
  logic        data_out_en_q, lvds_mode_q, dither_en_q, divider_realign_q;
  logic [7:0]  rd;
  int          errors = 0;
  int          checked = 0;
  int          pulses = 0;
  always #4 clk_sys = ~clk_sys;
  // moving converter data, so a stale or held word on the outputs shows up
  always @(posedge clk_sys)
    adc_data <= adc_data + 16'h0001;
  cdsc_top uut (.clk_sys, .srst, .spi_sclk, .spi_csb, .spi_sdio_i, .spi_sdio_o, .spi_sdio_oe_n, .sync_in,
    .output_disable_pin, .adc_data, .self_test_signature_high, .data_out_q, .data_out_en_q, .lvds_mode_q,
    .dither_en_q, .divider_realign_q);
  cdsc_host_model host (.clk_sys, .spi_sdio_o, .spi_sdio_oe_n, .spi_sclk, .spi_csb, .spi_sdio_i, .sync_in);
  // count realign pulses handed to the divider
  always @(posedge clk_sys)
    if (divider_realign_q === 1'b1)
      pulses++;
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rd);
  endtask
  task automatic rchk(input logic [12:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, rd);
    `CHK(rd, e)
  endtask
  // two pulses under one control setting, counting what reaches the divider
  task automatic sync_chk(input logic [7:0] ctrl, input int n);
    int p0;
    wr(13'h0100, ctrl);
    p0 = pulses;
    host.pulse();
    host.pulse();
    `CHK(pulses - p0, n)
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(data_out_en_q, 1'b0)
    `CHK(lvds_mode_q, 1'b0)
    rchk(13'h0025, 8'h5a);
    rchk(13'h0030, 8'h00);
    rchk(13'h0100, 8'h00);
    wr(13'h0025, 8'h00);
    rchk(13'h0025, 8'h5a);
    wr(13'h0030, 8'hff);
    rchk(13'h0030, 8'h10);
    `CHK(dither_en_q, 1'b1)
    rchk(13'h0031, 8'h00);
    sync_chk(8'h01, 0);
    sync_chk(8'h02, 0);
    sync_chk(8'h03, 2);
    sync_chk(8'h07, 1);
    rchk(13'h0100, 8'h05);
    wr(13'h0100, 8'hff);
    rchk(13'h0100, 8'h07);
    wr(13'h0100, 8'h00);
    wr(13'h0014, 8'h40);
    `CHK(lvds_mode_q, 1'b1)
    output_disable_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK(data_out_en_q, 1'b1)
    `CHK(data_out_q, adc_data - 16'h0001)
    output_disable_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    `CHK(data_out_en_q, 1'b0)
    `CHK(data_out_q, 16'h0000)
    tally_and_finish();
  end
endmodule
